/* File: hdl/scan_bridge_pkg.sv */
// Constants shared by the scan bridge register front end and its shifter.
// Assumes one 200 MHz clock for both the register port and the scan engine.
// How it works
// RULE1 - Config mode register map at eight word offsets
// RULE2 - Memory mode register map at seven offsets
// RULE3 - Capability header low half reads 0x000B
// RULE4 - Capability header version field reads 0x1
// RULE5 - Next capability pointer comes from parameter
// RULE6 - Vendor header low half gives identifier parameter
// RULE7 - Vendor header revision field defaults zero
// RULE8 - Vendor header length field reads 0x020
// RULE9 - Config base address is build parameter
// RULE10 - Memory mode is plain AXI4-Lite slave
// RULE11 - Config mode shares scan data word; memory splits
// RULE12 - Shift length register holds bit count
// RULE13 - Mode select register holds TMS pattern
// RULE14 - Host qualifies identity before reading vendor header
// RULE15 - Config path independent of memory traffic
// RULE16 - Version register read-only, fixed at build
// RULE17 - Start shifts bits LSB first, captures TDO
// RULE18 - Start bit held until shift completes
package scan_bridge_pkg;
    // Config mode byte offsets
    localparam logic [4:0] CFG_OFS_CAP = 5'h00;
    localparam logic [4:0] CFG_OFS_VSH = 5'h04;
    localparam logic [4:0] CFG_OFS_VER = 5'h08;
    localparam logic [4:0] CFG_OFS_LEN = 5'h0C;
    localparam logic [4:0] CFG_OFS_TMS = 5'h10;
    localparam logic [4:0] CFG_OFS_SCAN = 5'h14;
    localparam logic [4:0] CFG_OFS_CTL = 5'h18;
    localparam logic [4:0] CFG_OFS_STS = 5'h1C;
    // Memory mode byte offsets
    localparam logic [4:0] MM_OFS_LEN = 5'h00;
    localparam logic [4:0] MM_OFS_TMS = 5'h04;
    localparam logic [4:0] MM_OFS_TDI = 5'h08;
    localparam logic [4:0] MM_OFS_TDO = 5'h0C;
    localparam logic [4:0] MM_OFS_CTL = 5'h10;
    localparam logic [4:0] MM_OFS_STS = 5'h14;
    localparam logic [4:0] MM_OFS_VER = 5'h18;
    // Capability header fields
    localparam logic [15:0] CAP_ID_VSEC = 16'h000B;
    localparam logic [3:0] CAP_VERSION = 4'h1;
    localparam logic [11:0] VSEC_LENGTH = 12'h020;
    localparam int ID_LSB = 0;
    localparam int REV_LSB = 16;
    localparam int PTR_LSB = 20;
    // Control and status bits
    localparam int CTL_START_BIT = 0;
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_TDO_VALID_BIT = 1;
    // Reset values
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Scan clock timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TCK_HALF_NS = 10;
    localparam int TCK_HALF_CYC = ((TCK_HALF_NS * 1000) / CLK_PERIOD_PS < 1) ? 1 :
                                  (TCK_HALF_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [5:0] MAX_BITS = 6'h20;
    // Logical register selectors shared by both address maps
    typedef enum logic [3:0] {
        SEL_NONE = 4'h0, SEL_CAP = 4'h1, SEL_VSH = 4'h2, SEL_VER = 4'h3, SEL_LEN = 4'h4,
        SEL_TMS = 4'h5, SEL_TDI = 4'h6, SEL_TDO = 4'h7, SEL_SCAN = 4'h8, SEL_CTL = 4'h9,
        SEL_STS = 4'hA
    } reg_sel_t;
endpackage

/* File: hdl/scan_shifter.sv */
// Bit-serial scan engine: drives TCK/TMS/TDI and captures TDO, one word per run.
// Assumes scan_tdo_in is produced by logic clocked from this block's own TCK.
`timescale 1ns/1ps
module scan_shifter (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic start_in,
    input wire logic [31:0] length_in,
    input wire logic [31:0] tms_word_in,
    input wire logic [31:0] tdi_word_in,
    input wire logic scan_tdo_in,
    output logic busy_out,
    output logic [31:0] tdo_word_out,
    output logic scan_tck_out,
    output logic scan_tms_out,
    output logic scan_tdi_out
);
    typedef enum logic [2:0] {IDLE = 3'b001, LOW = 3'b010, HIGH = 3'b100} shift_state_t;
    shift_state_t state_r;
    logic [7:0] div_r;
    logic [5:0] bit_r;
    logic [5:0] count_r;
    wire div_end = (div_r == 8'(scan_bridge_pkg::TCK_HALF_CYC - 1));
    // Only one word is held, so longer requests are cut to 32 bits
    wire [5:0] count_clamped = (length_in > 32'(scan_bridge_pkg::MAX_BITS)) ?
                               scan_bridge_pkg::MAX_BITS : length_in[5:0];
    wire [5:0] bit_next = bit_r + 6'h01;
    wire last_bit = (bit_next == count_r);

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= IDLE;
            div_r <= 8'h00;
            bit_r <= 6'h00;
            count_r <= 6'h00;
            busy_out <= 1'b0;
            tdo_word_out <= scan_bridge_pkg::REG_RESET;
            scan_tck_out <= 1'b0;
            scan_tms_out <= 1'b0;
            scan_tdi_out <= 1'b0;
        end else begin
            unique case (state_r)
                IDLE: begin
                    div_r <= 8'h00;
                    if (start_in && count_clamped != 6'h00) begin
                        state_r <= LOW;
                        busy_out <= 1'b1;
                        bit_r <= 6'h00;
                        count_r <= count_clamped;
                        scan_tms_out <= tms_word_in[0]; // RULE17
                        scan_tdi_out <= tdi_word_in[0]; // RULE17
                    end
                end
                LOW: begin
                    div_r <= div_end ? 8'h00 : div_r + 8'h01;
                    if (div_end) begin
                        state_r <= HIGH;
                        scan_tck_out <= 1'b1;
                    end
                end
                HIGH: begin
                    div_r <= div_end ? 8'h00 : div_r + 8'h01;
                    if (div_end) begin
                        scan_tck_out <= 1'b0;
                        // TDO settles after the previous falling edge, so sample just before this one
                        tdo_word_out[bit_r[4:0]] <= scan_tdo_in; // RULE17
                        if (last_bit) begin
                            state_r <= IDLE;
                            busy_out <= 1'b0;
                        end else begin
                            state_r <= LOW;
                            bit_r <= bit_next;
                            scan_tms_out <= tms_word_in[bit_next[4:0]];
                            scan_tdi_out <= tdi_word_in[bit_next[4:0]];
                        end
                    end
                end
            endcase
        end
    end
endmodule

/* File: hdl/scan_bridge_regs.sv */
// Register front end of the scan bridge: config-space capability or AXI4-Lite window.
// Assumes the config port and AXI slave are on ref_clk_in; only the selected mode's port answers.
`timescale 1ns/1ps
module scan_bridge_regs #(
    parameter bit USE_CFG_MODE = 1'b1,
    parameter logic [11:0] CFG_BASE_BYTE = 12'h400,
    parameter logic [11:0] NEXT_CAP_PTR = 12'h000,
    // Arbitrary identification values
    parameter logic [15:0] VSEC_ID = 16'h5A31,
    parameter logic [3:0] VSEC_REV = 4'h0,
    parameter logic [31:0] BRIDGE_VERSION = 32'h0001_0003
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Extended configuration port
    input wire logic cfg_read_received_in,
    input wire logic cfg_write_received_in,
    input wire logic [9:0] cfg_register_number_in,
    input wire logic [31:0] cfg_write_data_in,
    input wire logic [3:0] cfg_write_byte_enable_in,
    output logic [31:0] cfg_read_data_out,
    output logic cfg_read_data_valid_out,
    // AXI4-Lite slave
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Scan chain
    output logic scan_tck_out,
    output logic scan_tms_out,
    output logic scan_tdi_out,
    input wire logic scan_tdo_in
);
    typedef scan_bridge_pkg::reg_sel_t sel_t;

    logic [31:0] len_r;
    logic [31:0] tms_r;
    logic [31:0] tdi_r;
    logic ctl_start_r;
    logic go_r;
    logic tdo_valid_r;
    logic shift_busy;
    logic [31:0] tdo_word;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic sel_t cfg_decode(input logic [4:0] ofs);
        unique case (ofs)
            scan_bridge_pkg::CFG_OFS_CAP: cfg_decode = scan_bridge_pkg::SEL_CAP;
            scan_bridge_pkg::CFG_OFS_VSH: cfg_decode = scan_bridge_pkg::SEL_VSH;
            scan_bridge_pkg::CFG_OFS_VER: cfg_decode = scan_bridge_pkg::SEL_VER;
            scan_bridge_pkg::CFG_OFS_LEN: cfg_decode = scan_bridge_pkg::SEL_LEN;
            scan_bridge_pkg::CFG_OFS_TMS: cfg_decode = scan_bridge_pkg::SEL_TMS;
            scan_bridge_pkg::CFG_OFS_SCAN: cfg_decode = scan_bridge_pkg::SEL_SCAN;
            scan_bridge_pkg::CFG_OFS_CTL: cfg_decode = scan_bridge_pkg::SEL_CTL;
            scan_bridge_pkg::CFG_OFS_STS: cfg_decode = scan_bridge_pkg::SEL_STS;
            default: cfg_decode = scan_bridge_pkg::SEL_NONE;
        endcase
    endfunction

    function automatic sel_t mm_decode(input logic [4:0] ofs);
        unique case (ofs)
            scan_bridge_pkg::MM_OFS_LEN: mm_decode = scan_bridge_pkg::SEL_LEN;
            scan_bridge_pkg::MM_OFS_TMS: mm_decode = scan_bridge_pkg::SEL_TMS;
            scan_bridge_pkg::MM_OFS_TDI: mm_decode = scan_bridge_pkg::SEL_TDI;
            scan_bridge_pkg::MM_OFS_TDO: mm_decode = scan_bridge_pkg::SEL_TDO;
            scan_bridge_pkg::MM_OFS_CTL: mm_decode = scan_bridge_pkg::SEL_CTL;
            scan_bridge_pkg::MM_OFS_STS: mm_decode = scan_bridge_pkg::SEL_STS;
            scan_bridge_pkg::MM_OFS_VER: mm_decode = scan_bridge_pkg::SEL_VER;
            default: mm_decode = scan_bridge_pkg::SEL_NONE;
        endcase
    endfunction

    // Config window: dword index relative to the build-time base; other capabilities answer elsewhere
    wire [9:0] cfg_base_dw = CFG_BASE_BYTE[11:2]; // RULE9
    wire [9:0] cfg_rel_dw = cfg_register_number_in - cfg_base_dw; // RULE9
    wire cfg_in_window = USE_CFG_MODE && (cfg_register_number_in >= cfg_base_dw) &&
                         (cfg_rel_dw < 10'h008);
    // Own decode straight off the config port, never routed through the memory window
    wire sel_t cfg_sel = cfg_in_window ? cfg_decode({cfg_rel_dw[2:0], 2'b00}) :
                                         scan_bridge_pkg::SEL_NONE; // RULE1 RULE15
    wire cfg_wr = cfg_write_received_in && cfg_in_window;
    wire cfg_rd = cfg_read_received_in && cfg_in_window;

    // AXI4-Lite handshakes; valid is held by the master until ready
    wire axi_wr = !USE_CFG_MODE && s_axi_awready && s_axi_awvalid && s_axi_wvalid; // RULE10
    wire axi_rd = !USE_CFG_MODE && s_axi_arready && s_axi_arvalid; // RULE10
    wire sel_t aw_sel = mm_decode({s_axi_awaddr[4:2], 2'b00}); // RULE2
    wire sel_t ar_sel = mm_decode({s_axi_araddr[4:2], 2'b00}); // RULE2
    wire [4:0] aw_ofs = {s_axi_awaddr[4:2], 2'b00};
    wire aw_mapped = (aw_ofs == scan_bridge_pkg::MM_OFS_LEN) || (aw_ofs == scan_bridge_pkg::MM_OFS_TMS) ||
                     (aw_ofs == scan_bridge_pkg::MM_OFS_TDI) || (aw_ofs == scan_bridge_pkg::MM_OFS_CTL);
    wire ar_mapped = (ar_sel != scan_bridge_pkg::SEL_NONE);

    // Merged write request from whichever port is live
    wire wr_en = cfg_wr || axi_wr;
    wire sel_t wr_sel = cfg_wr ? cfg_sel : (axi_wr ? aw_sel : scan_bridge_pkg::SEL_NONE);
    wire [31:0] wr_data = cfg_wr ? cfg_write_data_in : s_axi_wdata;
    wire [3:0] wr_be = cfg_wr ? cfg_write_byte_enable_in : s_axi_wstrb;
    // Length, scan data and control writes are all frozen while the start bit is set so the engine sees a stable pattern
    wire wr_ok = wr_en && !ctl_start_r;
    wire wr_len = wr_ok && (wr_sel == scan_bridge_pkg::SEL_LEN);
    wire wr_tms = wr_ok && (wr_sel == scan_bridge_pkg::SEL_TMS);
    wire wr_tdi = wr_ok && ((wr_sel == scan_bridge_pkg::SEL_TDI) || (wr_sel == scan_bridge_pkg::SEL_SCAN)); // RULE11
    wire wr_go = wr_ok && (wr_sel == scan_bridge_pkg::SEL_CTL) && wr_be[0] && wr_data[scan_bridge_pkg::CTL_START_BIT];

    wire [31:0] cap_word = {NEXT_CAP_PTR, scan_bridge_pkg::CAP_VERSION, scan_bridge_pkg::CAP_ID_VSEC}; // RULE3 RULE4 RULE5
    wire [31:0] vsh_word = {scan_bridge_pkg::VSEC_LENGTH, VSEC_REV, VSEC_ID}; // RULE6 RULE7 RULE8
    wire [31:0] sts_word = {30'h0000_0000, tdo_valid_r, ctl_start_r};
    wire [31:0] ctl_word = {31'h0000_0000, ctl_start_r};
    wire sel_t rd_sel = cfg_rd ? cfg_sel : ar_sel;
    wire [31:0] rd_data =
        (rd_sel == scan_bridge_pkg::SEL_CAP) ? cap_word :
        (rd_sel == scan_bridge_pkg::SEL_VSH) ? vsh_word :
        (rd_sel == scan_bridge_pkg::SEL_VER) ? BRIDGE_VERSION : // RULE16
        (rd_sel == scan_bridge_pkg::SEL_LEN) ? len_r :
        (rd_sel == scan_bridge_pkg::SEL_TMS) ? tms_r :
        (rd_sel == scan_bridge_pkg::SEL_TDI) ? tdi_r :
        (rd_sel == scan_bridge_pkg::SEL_TDO || rd_sel == scan_bridge_pkg::SEL_SCAN) ? tdo_word : // RULE11
        (rd_sel == scan_bridge_pkg::SEL_CTL) ? ctl_word :
        (rd_sel == scan_bridge_pkg::SEL_STS) ? sts_word : scan_bridge_pkg::REG_RESET;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            len_r <= scan_bridge_pkg::REG_RESET;
            tms_r <= scan_bridge_pkg::REG_RESET;
            tdi_r <= scan_bridge_pkg::REG_RESET;
        end else begin
            if (wr_len) len_r <= merge_bytes(len_r, wr_data, wr_be); // RULE12
            if (wr_tms) tms_r <= merge_bytes(tms_r, wr_data, wr_be); // RULE13
            if (wr_tdi) tdi_r <= merge_bytes(tdi_r, wr_data, wr_be);
        end
    end

    // Start bit: set by software, held through the shift, cleared by completion
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctl_start_r <= 1'b0;
            go_r <= 1'b0;
            tdo_valid_r <= 1'b0;
        end else begin
            go_r <= wr_go;
            if (wr_go) begin
                ctl_start_r <= 1'b1; // RULE18
                tdo_valid_r <= 1'b0;
            end else if (ctl_start_r && !go_r && !shift_busy) begin
                ctl_start_r <= 1'b0; // RULE18
                tdo_valid_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_read_data_out <= scan_bridge_pkg::REG_RESET;
            cfg_read_data_valid_out <= 1'b0;
        end else begin
            cfg_read_data_valid_out <= cfg_rd; // RULE1
            cfg_read_data_out <= cfg_rd ? rd_data : scan_bridge_pkg::REG_RESET;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= scan_bridge_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !USE_CFG_MODE && s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !USE_CFG_MODE && s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            if (axi_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_mapped ? scan_bridge_pkg::RESP_OKAY : scan_bridge_pkg::RESP_SLVERR; // RULE10
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= scan_bridge_pkg::REG_RESET;
            s_axi_rresp <= scan_bridge_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !USE_CFG_MODE && s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (axi_rd) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= ar_mapped ? scan_bridge_pkg::RESP_OKAY : scan_bridge_pkg::RESP_SLVERR; // RULE10
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    scan_shifter u_shifter (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .start_in(go_r),
        .length_in(len_r),
        .tms_word_in(tms_r),
        .tdi_word_in(tdi_r),
        .scan_tdo_in(scan_tdo_in),
        .busy_out(shift_busy),
        .tdo_word_out(tdo_word),
        .scan_tck_out(scan_tck_out),
        .scan_tms_out(scan_tms_out),
        .scan_tdi_out(scan_tdi_out)
    );

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    property p_cap_id;
        cfg_rd && cfg_sel == scan_bridge_pkg::SEL_CAP |=> cfg_read_data_out[15:0] == 16'h000B;
    endproperty
    a_cap_id: assert property (p_cap_id) else $error("capability id wrong"); // RULE3
    property p_cap_ver;
        cfg_rd && cfg_sel == scan_bridge_pkg::SEL_CAP |=> cfg_read_data_valid_out && cfg_read_data_out[19:16] == 4'h1;
    endproperty
    a_cap_ver: assert property (p_cap_ver) else $error("capability version wrong"); // RULE4
    property p_next_ptr;
        cfg_rd && cfg_sel == scan_bridge_pkg::SEL_CAP |=> cfg_read_data_out[31:20] == NEXT_CAP_PTR;
    endproperty
    a_next_ptr: assert property (p_next_ptr) else $error("next pointer wrong"); // RULE5
    property p_vsec_id;
        cfg_rd && cfg_sel == scan_bridge_pkg::SEL_VSH |=> cfg_read_data_out[15:0] == VSEC_ID;
    endproperty
    a_vsec_id: assert property (p_vsec_id) else $error("vendor id wrong"); // RULE6
    property p_vsec_rev;
        cfg_rd && cfg_sel == scan_bridge_pkg::SEL_VSH |=> cfg_read_data_out[19:16] == VSEC_REV;
    endproperty
    a_vsec_rev: assert property (p_vsec_rev) else $error("vendor revision wrong"); // RULE7
    property p_vsec_len;
        cfg_rd && cfg_sel == scan_bridge_pkg::SEL_VSH |=> cfg_read_data_out[31:20] == 12'h020;
    endproperty
    a_vsec_len: assert property (p_vsec_len) else $error("structure length wrong"); // RULE8
    property p_version;
        cfg_rd && cfg_sel == scan_bridge_pkg::SEL_VER |=> cfg_read_data_out == BRIDGE_VERSION;
    endproperty
    a_version: assert property (p_version) else $error("version read wrong"); // RULE16
    property p_scan_read;
        cfg_rd && cfg_sel == scan_bridge_pkg::SEL_SCAN |=> cfg_read_data_out == $past(tdo_word);
    endproperty
    a_scan_read: assert property (p_scan_read) else $error("scan data read is not captured TDO"); // RULE11
    property p_len_write;
        wr_ok && wr_sel == scan_bridge_pkg::SEL_LEN && wr_be == 4'hF |=> len_r == $past(wr_data);
    endproperty
    a_len_write: assert property (p_len_write) else $error("shift length not stored"); // RULE12
    property p_start_held;
        shift_busy |-> ctl_start_r;
    endproperty
    a_start_held: assert property (p_start_held) else $error("start bit dropped mid-shift"); // RULE18
    property p_start_clear;
        $fell(shift_busy) |=> !ctl_start_r && tdo_valid_r;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start bit not cleared at end"); // RULE18
    property p_tck_high;
        $rose(scan_tck_out) |-> ##1 scan_tck_out ##1 !scan_tck_out;
    endproperty
    a_tck_high: assert property (p_tck_high) else $error("scan clock high time wrong"); // RULE17
    property p_unmapped_read;
        axi_rd && !ar_mapped |=> s_axi_rvalid && s_axi_rresp == 2'h2;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not refused"); // RULE10

    c_cfg_read: cover property (cfg_rd ##1 cfg_read_data_valid_out);
    c_shift_done: cover property ($fell(shift_busy));
    c_axi_write: cover property (axi_wr ##1 s_axi_bvalid);
    c_axi_read: cover property (axi_rd ##1 s_axi_rvalid);
endmodule

/* File: dv/scan_chain_model.sv */
// Stand-in for the debug scan chain behind the bridge: a 32-bit shift path on TCK.
// Assumes the bridge samples TDO at the end of TCK high, before the falling edge shifts it.
`timescale 1ns/1ps
module scan_chain_model (
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out
);
    logic [31:0] chain_r = 32'h0000_0000;
    logic [31:0] tdi_seen = 32'h0000_0000;
    logic [31:0] tms_seen = 32'h0000_0000;
    assign tdo_out = chain_r[0];
    // Capture mid-bit, since the bridge moves TMS/TDI on the same edge that drops TCK
    always @(posedge tck_in) begin
        tdi_seen = {tdi_in, tdi_seen[31:1]};
        tms_seen = {tms_in, tms_seen[31:1]};
    end
    // Refill with the inverse so a stale bit never looks correct
    always @(negedge tck_in) begin
        chain_r = {~chain_r[0], chain_r[31:1]};
    end
    task automatic load(input logic [31:0] v);
        chain_r = v;
    endtask
endmodule

/* File: dv/test_scan_bridge_regs.sv */
// Self-checking bench for the scan bridge register front end in config-space mode, plus a memory-mapped copy.
// Assumes the AXI window stays silent in this mode; the chain model answers TDO.
`timescale 1ns/1ps
module test_scan_bridge_regs;
    localparam logic [9:0] BASE = 10'h100;
    logic ref_clk_in = 1'b0, rstn_in = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [9:0] rn = 10'h000;
    logic [31:0] wd = 32'h0, rdat, s1 = 32'h1D, s2 = 32'h1D, ax = 32'h0, d;
    logic [3:0] be = 4'h0;
    logic rv, tck, tms, tdi, tdo, awr, wrr, bv, arr, rvl;
    logic [31:0] mdl [8];
    int lens [4] = '{1, 17, 32, 40};
    int num_errors = 0, n_checks = 0;
    logic [4:0] ma = 5'h00;
    logic mav = 1'b0, mar = 1'b0, mawr, marr, mbv, mrv;
    logic [31:0] mwd = 32'h0, mrd;
    logic [1:0] mbr, mrr;
    always #2.5 ref_clk_in = ~ref_clk_in;
    // Identity values are arbitrary
    scan_bridge_regs #(.NEXT_CAP_PTR(12'h150), .VSEC_ID(16'h6B2E), .BRIDGE_VERSION(32'h0002_0004)) dut_u (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .cfg_read_received_in(rd), .cfg_write_received_in(wr),
        .cfg_register_number_in(rn), .cfg_write_data_in(wd), .cfg_write_byte_enable_in(be),
        .cfg_read_data_out(rdat), .cfg_read_data_valid_out(rv), .s_axi_awaddr(ax[4:0]), .s_axi_awvalid(ax[5]),
        .s_axi_awready(awr), .s_axi_wdata(ax), .s_axi_wstrb(ax[9:6]), .s_axi_wvalid(ax[10]), .s_axi_wready(wrr),
        .s_axi_bresp(), .s_axi_bvalid(bv), .s_axi_bready(ax[11]), .s_axi_araddr(ax[16:12]),
        .s_axi_arvalid(ax[17]), .s_axi_arready(arr), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(rvl),
        .s_axi_rready(ax[18]), .scan_tck_out(tck), .scan_tms_out(tms), .scan_tdi_out(tdi), .scan_tdo_in(tdo));
    scan_chain_model chain_u (.tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo));
    // Second copy in memory-mapped mode; its config port sees the same traffic and must ignore it
    scan_bridge_regs #(.USE_CFG_MODE(1'b0), .BRIDGE_VERSION(32'h0002_0004)) dut_m (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .cfg_read_received_in(rd), .cfg_write_received_in(wr),
        .cfg_register_number_in(rn), .cfg_write_data_in(wd), .cfg_write_byte_enable_in(be),
        .cfg_read_data_out(), .cfg_read_data_valid_out(), .s_axi_awaddr(ma), .s_axi_awvalid(mav),
        .s_axi_awready(mawr), .s_axi_wdata(mwd), .s_axi_wstrb(4'hF), .s_axi_wvalid(mav), .s_axi_wready(),
        .s_axi_bresp(mbr), .s_axi_bvalid(mbv), .s_axi_bready(1'b1), .s_axi_araddr(ma), .s_axi_arvalid(mar),
        .s_axi_arready(marr), .s_axi_rdata(mrd), .s_axi_rresp(mrr), .s_axi_rvalid(mrv), .s_axi_rready(1'b1),
        .scan_tck_out(), .scan_tms_out(), .scan_tdi_out(), .scan_tdo_in(1'b0));
    function automatic logic [31:0] xs(inout logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cfg_wr(input int i, input logic [31:0] x, input logic [3:0] b);
        @(negedge ref_clk_in);
        wr = 1'b1;
        rn = BASE + 10'(i);
        wd = x;
        be = b;
        @(negedge ref_clk_in);
        wr = 1'b0;
    endtask
    task automatic cfg_rd(input int i, input logic ex, output logic [31:0] g);
        @(negedge ref_clk_in);
        rd = 1'b1;
        rn = BASE + 10'(i);
        @(negedge ref_clk_in);
        rd = 1'b0;
        chk(32'(ex), 32'(rv));
        g = rdat;
    endtask
    // Ready is registered, so the handshake edge is the one after ready is first seen high
    task automatic axi_op(input logic w, input logic [4:0] a, input logic [31:0] x, input logic [1:0] er,
                          output logic [31:0] g);
        @(negedge ref_clk_in);
        ma = a;
        mwd = x;
        mav = w;
        mar = !w;
        do @(negedge ref_clk_in); while ((w ? mawr : marr) !== 1'b1);
        @(negedge ref_clk_in);
        mav = 1'b0;
        mar = 1'b0;
        chk({30'h0, er}, w ? {30'h0, mbr} : {30'h0, mrr});
        chk(32'h1, w ? 32'(mbv) : 32'(mrv));
        g = mrd;
    endtask
    // The AXI side is fed noise; in config mode it must never answer
    always @(negedge ref_clk_in) begin
        if (rstn_in) chk(32'h0, {27'h0, awr, wrr, bv, arr, rvl});
        ax <= xs(s2);
    end
    initial begin
        int n, eff;
        logic [31:0] t, c, m, v;
        for (int k = 0; k < 8; k++) mdl[k] = 32'h0;
        repeat (8) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        rstn_in = 1'b1;
        for (int k = 0; k < 3; k++) cfg_wr(k, xs(s1), 4'hF);
        cfg_rd(0, 1'b1, d);
        chk({12'h150, 4'h1, 16'h000B}, d);
        cfg_rd(1, 1'b1, d);
        chk({12'h020, 4'h0, 16'h6B2E}, d);
        cfg_rd(2, 1'b1, d);
        chk(32'h0002_0004, d);
        cfg_rd(7, 1'b1, d);
        chk(32'h0, d);
        cfg_rd(8, 1'b0, d);
        chk(32'h0, d);
        for (int k = 3; k < 5; k++) begin
            v = xs(s1);
            cfg_wr(k, v, 4'h5);
            mdl[k] = (mdl[k] & 32'hFF00_FF00) | (v & 32'h00FF_00FF);
            cfg_rd(k, 1'b1, d);
            chk(mdl[k], d);
        end
        foreach (lens[j]) begin
            v = xs(s1);
            t = xs(s1);
            c = xs(s1);
            chain_u.load(c);
            cfg_wr(3, 32'(lens[j]), 4'hF);
            cfg_wr(4, v, 4'hF);
            cfg_wr(5, t, 4'hF);
            cfg_wr(6, 32'h1, 4'hF);
            cfg_rd(6, 1'b1, d);
            chk(32'h1, d & 32'h1);
            cfg_wr(3, 32'h5, 4'hF);
            n = 0;
            do begin
                cfg_rd(6, 1'b1, d);
                n++;
            end while (d[0] !== 1'b0 && n < 100);
            chk(32'h0, d & 32'h1);
            eff = (lens[j] > 32) ? 32 : lens[j];
            m = (eff == 32) ? 32'hFFFF_FFFF : (32'h1 << eff) - 32'h1;
            cfg_rd(5, 1'b1, d);
            chk(c & m, d & m);
            chk(t & m, (chain_u.tdi_seen >> (32 - eff)) & m);
            chk(v & m, (chain_u.tms_seen >> (32 - eff)) & m);
            cfg_rd(7, 1'b1, d);
            chk(32'h2, d & 32'h3);
            cfg_rd(3, 1'b1, d);
            chk(32'(lens[j]), d);
        end
        v = xs(s1);
        axi_op(1'b1, 5'h00, v, 2'h0, d);
        axi_op(1'b0, 5'h00, 32'h0, 2'h0, d);
        chk(v, d);
        axi_op(1'b1, 5'h08, ~v, 2'h0, d);
        axi_op(1'b1, 5'h0C, v, 2'h2, d);
        axi_op(1'b0, 5'h08, 32'h0, 2'h0, d);
        chk(~v, d);
        axi_op(1'b0, 5'h0C, 32'h0, 2'h0, d);
        chk(32'h0, d);
        axi_op(1'b0, 5'h18, 32'h0, 2'h0, d);
        chk(32'h0002_0004, d);
        axi_op(1'b0, 5'h1C, 32'h0, 2'h2, d);
        chk(32'h0, d);
        close_out();
    end
    initial begin
        #40000;
        num_errors++;
        close_out();
    end
endmodule
